/* File: include/csp_pkg.sv */
// Shared constants and types of the clock synthesis loop control block
package csp_pkg;

  // Reference source codes
  localparam logic [1:0] REF_SEL_PIN    = 2'h0;
  localparam logic [1:0] REF_SEL_OSC    = 2'h1;
  localparam logic [1:0] REF_SEL_FABRIC = 2'h2;

  // Feedback source codes
  localparam logic FB_SEL_FABRIC = 1'h0;
  localparam logic FB_SEL_PIN    = 1'h1;

  // Field widths
  localparam int FB_DIV_W   = 7;
  localparam int OUT_EXP_W  = 3;
  localparam int PH_MAG_W   = 8;
  localparam int PER_W      = 16;
  localparam int DIV_CNT_W  = 6;
  localparam int SYNC_W     = 7;

  // Largest output divide exponent (divide by 64)
  localparam logic [OUT_EXP_W-1:0] OUT_EXP_MAX = 3'h6;

  // Phase shift setting: delay or advance by a count of accumulator units, each 1/(2*fb_div) of a system clock cycle
  typedef struct packed {
    logic                dly;
    logic [PH_MAG_W-1:0] mag;
  } csp_phase_t;

  // Loop settings, shifted in serially MSB first (23 bits)
  typedef struct packed {
    logic [FB_DIV_W-1:0]  fb_div;
    logic [OUT_EXP_W-1:0] out_exp;
    logic [1:0]           ref_sel;
    logic                 fb_sel;
    logic                 ph_dynamic;
    csp_phase_t           phase;
  } csp_cfg_t;

  localparam int CFG_W = $bits(csp_cfg_t);

  // Settings after system reset: x1, divide by 1, pin reference, internal feedback
  localparam csp_cfg_t CFG_RESET = '{fb_div: 7'h01, out_exp: 3'h0, ref_sel: 2'h0,
                                     fb_sel: 1'h0, ph_dynamic: 1'h0,
                                     phase: '{dly: 1'h0, mag: 8'h00}};

  // Lock settling time
  localparam int CLK_HZ          = 20_000_000;
  localparam int SETTLE_TIME_NS  = 50_000;
  localparam int SETTLE_CYC      = (SETTLE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_W        = 11;

endpackage : csp_pkg

/* File: hdl/csp_loop_ctrl.sv */
// Clock synthesis loop control: source select, multiply, divide, phase, lock, serial setup
//
// Overview of operation
// - Reference from pin, oscillator or fabric.
// - Feedback from fabric route or pin.
// - Output frequency is reference times feedback divider.
// - Output divider 1 to 64, powers of two.
// - Output drives global network and fabric.
// - Lock raised when locked, dropped on loss.
// - Phase shift advances or delays output.
// - Phase fixed by settings or changed live.
// - Live phase change drops lock until settled, with fabric feedback only.
// - Serial bits shifted in as pending settings.
// - Loop reset pulse applies pending settings, relocks.
`timescale 1ns/1ps

module csp_loop_ctrl
  import csp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ref_pin,
  input  wire logic              i_ref_osc,
  input  wire logic              i_ref_fabric,
  input  wire logic              i_fb_pin,
  input  wire logic              i_cfg_shift_clk,
  input  wire logic              i_cfg_shift_data,
  input  wire logic              i_loop_rst,
  input  wire csp_pkg::csp_phase_t i_dyn_phase,
  output logic                   o_synth_clk_gbuf,
  output logic                   o_synth_clk_fabric,
  output logic                   o_lock,
  output csp_pkg::csp_cfg_t      o_active_cfg,
  output csp_pkg::csp_cfg_t      o_pending_cfg
);
  import csp_pkg::*;

  typedef enum logic [1:0] {LK_HOLD, LK_SETTLE, LK_LOCKED} csp_lock_t;

  // Input synchronisers; stage one is read only by stage two
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  csp_phase_t        ph_sync1;
  csp_phase_t        ph_sync2;
  csp_phase_t        ph_sync3;
  csp_phase_t        ph_live, next_ph_live;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1    <= '0;
      sync2    <= '0;
      ph_sync1 <= '0;
      ph_sync2 <= '0;
      ph_sync3 <= '0;
      ph_live  <= '0;
    end else begin
      sync1    <= {i_ref_pin, i_ref_osc, i_ref_fabric, i_fb_pin,
                   i_cfg_shift_clk, i_cfg_shift_data, i_loop_rst};
      sync2    <= sync1;
      ph_sync1 <= i_dyn_phase;
      ph_sync2 <= ph_sync1;
      ph_sync3 <= ph_sync2;
      ph_live  <= next_ph_live;
    end
  end

  // The phase word is synced bit by bit, so it is taken only once two samples agree
  always_comb begin
    next_ph_live = ph_live;
    if (ph_sync2 == ph_sync3) begin
      next_ph_live = ph_sync2;
    end
  end

  logic ref_pin_s;
  logic ref_osc_s;
  logic ref_fab_s;
  logic fb_pin_s;
  logic sclk_s;
  logic sdata_s;
  logic loop_rst_s;
  assign {ref_pin_s, ref_osc_s, ref_fab_s, fb_pin_s, sclk_s, sdata_s, loop_rst_s} = sync2;

  // Serial settings port and active settings
  csp_cfg_t pending, next_pending;
  csp_cfg_t active, next_active;
  logic     sclk_q, next_sclk_q;

  always_comb begin
    next_sclk_q  = sclk_s;
    next_pending = pending;
    next_active  = active;
    if (sclk_s && !sclk_q) begin
      next_pending = csp_cfg_t'({pending[CFG_W-2:0], sdata_s});
    end
    // Settings swap only under loop reset, so a half-shifted word never takes effect
    if (loop_rst_s) begin
      next_active = pending;
      if (pending.out_exp > OUT_EXP_MAX) begin
        next_active.out_exp = OUT_EXP_MAX;
      end
      if (pending.fb_div == '0) begin
        next_active.fb_div = 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q  <= 1'b0;
      pending <= CFG_RESET;
      active  <= CFG_RESET;
    end else begin
      sclk_q  <= next_sclk_q;
      pending <= next_pending;
      active  <= next_active;
    end
  end

  // Reference selection and period measurement
  logic ref_clk_in;
  always_comb begin
    case (active.ref_sel)
      REF_SEL_PIN:    ref_clk_in = ref_pin_s;
      REF_SEL_OSC:    ref_clk_in = ref_osc_s;
      REF_SEL_FABRIC: ref_clk_in = ref_fab_s;
      default:        ref_clk_in = ref_pin_s;
    endcase
  end

  csp_phase_t       phase_now;
  logic             ref_q, next_ref_q;
  logic             ref_edge;
  logic [PER_W-1:0] per_cnt, next_per_cnt;
  logic [PER_W-1:0] per_last, next_per_last;
  logic [PER_W-1:0] acc, next_acc;
  logic [PER_W:0]   acc_sum;
  logic [PER_W-1:0] preload;
  logic [PER_W-1:0] acc_base;
  logic             synth_clk_out, next_synth;
  logic [DIV_CNT_W-1:0] div_cnt, next_div_cnt;
  logic             out_q, next_out;

  assign phase_now = active.ph_dynamic ? ph_live : active.phase;
  assign ref_edge  = ref_clk_in && !ref_q;

  always_comb begin
    next_ref_q    = ref_clk_in;
    next_per_cnt  = per_cnt + 16'h0001;
    next_per_last = per_last;
    next_synth    = synth_clk_out;
    next_div_cnt  = div_cnt;
    next_acc      = acc;
    // Offset kept below one period so the preload stays inside the accumulator range
    if (phase_now.dly) begin
      preload = (per_last > {8'h00, phase_now.mag}) ? per_last - {8'h00, phase_now.mag}
                                                    : 16'h0000;
    end else begin
      preload = (per_last > {8'h00, phase_now.mag}) ? {8'h00, phase_now.mag}
                                                    : 16'h0000;
    end
    // The reference edge cycle steps as well, else each period loses one step
    acc_base      = ref_edge ? preload : acc;
    // Bresenham step: 2*fb_div toggles per reference period
    acc_sum       = {1'b0, acc_base}
                  + {{(PER_W-FB_DIV_W){1'b0}}, active.fb_div, 1'b0};
    if (ref_edge) begin
      next_per_cnt  = 16'h0001;
      next_per_last = per_cnt;
    end
    if (per_last != '0) begin
      if (acc_sum >= {1'b0, per_last}) begin
        next_acc   = acc_sum[PER_W-1:0] - per_last;
        next_synth = !synth_clk_out;
        if (!synth_clk_out) begin
          next_div_cnt = div_cnt + 6'h01;
        end
      end else begin
        next_acc = acc_sum[PER_W-1:0];
      end
    end
    // Loop reset parks the output low and restarts the accumulator
    if (loop_rst_s) begin
      next_acc     = '0;
      next_synth   = 1'b0;
      next_div_cnt = '0;
    end
    if (active.out_exp == '0) begin
      next_out = synth_clk_out;
    end else begin
      next_out = div_cnt[active.out_exp - 3'h1];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_q         <= 1'b0;
      per_cnt       <= '0;
      per_last      <= '0;
      acc           <= '0;
      synth_clk_out <= 1'b0;
      div_cnt       <= '0;
      out_q         <= 1'b0;
    end else begin
      ref_q         <= next_ref_q;
      per_cnt       <= next_per_cnt;
      per_last      <= next_per_last;
      acc           <= next_acc;
      synth_clk_out <= next_synth;
      div_cnt       <= next_div_cnt;
      out_q         <= next_out;
    end
  end

  // One flop feeds both loads so the two copies never skew
  assign o_synth_clk_gbuf   = out_q;
  assign o_synth_clk_fabric = out_q;

  // Lock detection: count feedback rising edges per reference period
  csp_lock_t           lk_state, next_lk_state;
  logic                loop_feedback_in;
  logic                fb_q, next_fb_q;
  logic [7:0]          fb_cnt, next_fb_cnt;
  logic [SETTLE_W-1:0] settle_cnt, next_settle_cnt;
  csp_phase_t          ph_q, next_ph_q;
  logic                period_ok;
  logic                ph_moved;

  // Feedback is the undivided synthesized clock, internally or looped back on a pin
  assign loop_feedback_in = (active.fb_sel == FB_SEL_PIN) ? fb_pin_s : synth_clk_out;
  // One edge of slack either way, for an edge that meets the reference edge
  assign period_ok = (fb_cnt + 8'h01 >= {1'b0, active.fb_div})
                  && (fb_cnt <= {1'b0, active.fb_div} + 8'h01);
  assign ph_moved  = active.ph_dynamic && (ph_live != ph_q);

  always_comb begin
    next_fb_q       = loop_feedback_in;
    next_ph_q       = ph_live;
    next_fb_cnt     = fb_cnt;
    next_settle_cnt = settle_cnt;
    next_lk_state   = lk_state;
    if (loop_feedback_in && !fb_q && fb_cnt != 8'hFF) begin
      next_fb_cnt = fb_cnt + 8'h01;
    end
    if (ref_edge) begin
      next_fb_cnt = '0;
    end
    if (settle_cnt != SETTLE_CYC[SETTLE_W-1:0]) begin
      next_settle_cnt = settle_cnt + 11'h001;
    end
    // Lock is declared only at a reference edge after a full settle count
    case (lk_state)
      LK_HOLD: begin
        next_settle_cnt = '0;
        next_lk_state   = LK_SETTLE;
      end
      LK_SETTLE: begin
        if (ref_edge && !period_ok) begin
          next_settle_cnt = '0;
        end else if (ref_edge && settle_cnt == SETTLE_CYC[SETTLE_W-1:0]) begin
          next_lk_state = LK_LOCKED;
        end
      end
      LK_LOCKED: begin
        if (ref_edge && !period_ok) begin
          next_lk_state = LK_HOLD;
        end
      end
      default: next_lk_state = LK_HOLD;
    endcase
    // A live phase step may disturb the feedback, so settling restarts in full
    if (ph_moved && active.fb_sel == FB_SEL_FABRIC) begin
      next_lk_state = LK_HOLD;
    end
    if (loop_rst_s) begin
      next_lk_state = LK_HOLD;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lk_state   <= LK_HOLD;
      fb_q       <= 1'b0;
      fb_cnt     <= '0;
      settle_cnt <= '0;
      ph_q       <= '0;
    end else begin
      lk_state   <= next_lk_state;
      fb_q       <= next_fb_q;
      fb_cnt     <= next_fb_cnt;
      settle_cnt <= next_settle_cnt;
      ph_q       <= next_ph_q;
    end
  end

  assign o_lock        = (lk_state == LK_LOCKED);
  assign o_active_cfg  = active;
  assign o_pending_cfg = pending;

endmodule : csp_loop_ctrl

/* File: verification/csp_loop_ctrl_asserts.sv */
// Concurrent checks on the loop control ports
`timescale 1ns/1ps
module csp_loop_ctrl_asserts (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_cfg_shift_clk,
  input  wire logic              i_loop_rst,
  input  wire logic              o_synth_clk_gbuf,
  input  wire logic              o_synth_clk_fabric,
  input  wire logic              o_lock,
  input  wire csp_pkg::csp_cfg_t o_active_cfg,
  input  wire csp_pkg::csp_cfg_t o_pending_cfg
);
  import csp_pkg::*;
  logic [10:0] low_cnt;
  logic [10:0] next_low_cnt;
  // Saturates so a long unlocked stretch cannot wrap
  always_comb begin
    next_low_cnt = low_cnt;
    if (o_lock) next_low_cnt = 11'h000;
    else if (low_cnt != 11'h7FF) next_low_cnt = low_cnt + 11'h001;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) low_cnt <= 11'h000;
    else low_cnt <= next_low_cnt;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence rst_held; i_loop_rst [*4]; endsequence
  sequence sclk_idle; !i_cfg_shift_clk [*6]; endsequence
  lock_in_rst_a: assert property (rst_held |-> !o_lock)
    else $error("lock high in loop reset");
  apply_cfg_a: assert property (rst_held |-> o_active_cfg[12:0] == o_pending_cfg[12:0])
    else $error("settings not applied");
  stop_in_rst_a: assert property (i_loop_rst [*6] |-> !o_synth_clk_gbuf)
    else $error("output runs in loop reset");
  div_range_a: assert property (o_active_cfg.out_exp <= OUT_EXP_MAX)
    else $error("output divider out of range");
  fb_div_ok_a: assert property (o_active_cfg.fb_div != 7'h00)
    else $error("feedback divider zero");
  out_same_a: assert property (o_synth_clk_gbuf == o_synth_clk_fabric)
    else $error("outputs differ");
  settle_wait_a: assert property ($rose(o_lock) |-> low_cnt >= SETTLE_CYC[10:0])
    else $error("lock before settle time");
  shift_order_a: assert property ($changed(o_pending_cfg) |->
    o_pending_cfg[CFG_W-1:1] == $past(o_pending_cfg[CFG_W-2:0]))
    else $error("pending not shifted by one");
  shift_idle_a: assert property (sclk_idle |-> $stable(o_pending_cfg))
    else $error("pending moved without shift clock");
endmodule : csp_loop_ctrl_asserts

bind csp_loop_ctrl csp_loop_ctrl_asserts u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_cfg_shift_clk(i_cfg_shift_clk), .i_loop_rst(i_loop_rst),
  .o_synth_clk_gbuf(o_synth_clk_gbuf), .o_synth_clk_fabric(o_synth_clk_fabric),
  .o_lock(o_lock), .o_active_cfg(o_active_cfg), .o_pending_cfg(o_pending_cfg));

/* File: verification/csp_user_model.sv */
// User logic model: reference source, feedback loop-back, serial setup
`timescale 1ns/1ps
module csp_user_model (
  input  wire logic i_clk,
  input  wire logic i_synth_clk,
  output logic      o_ref_pin,
  output logic      o_ref_osc,
  output logic      o_ref_fabric,
  output logic      o_fb_pin,
  output logic      o_shift_clk,
  output logic      o_shift_data,
  output logic      o_loop_rst
);
  logic [1:0] ref_wire = 2'h0;
  logic       fb_loop  = 1'h0;
  logic       ref_lvl  = 1'h0;
  logic [4:0] ref_cnt  = 5'h00;
  initial begin
    o_shift_clk = 1'h0;
    o_shift_data = 1'h0;
    o_loop_rst = 1'h0;
  end
  // Reference of 40 cycles, long enough for the largest multiplier used
  always @(posedge i_clk) begin
    ref_cnt <= (ref_cnt == 5'h13) ? 5'h00 : ref_cnt + 5'h01;
    if (ref_cnt == 5'h13) ref_lvl <= !ref_lvl;
  end
  assign o_ref_pin = ref_lvl & (ref_wire == 2'h0);
  assign o_ref_osc = ref_lvl & (ref_wire == 2'h1);
  assign o_ref_fabric = ref_lvl & (ref_wire == 2'h2);
  assign o_fb_pin = fb_loop & i_synth_clk;
  task automatic shift_word(input logic [22:0] w);
    for (int b = 22; b >= 0; b--) begin
      @(posedge i_clk);
      o_shift_data <= w[b];
      o_shift_clk <= 1'h0;
      repeat (3) @(posedge i_clk);
      o_shift_clk <= 1'h1;
      repeat (3) @(posedge i_clk);
    end
    o_shift_clk <= 1'h0;
    o_shift_data <= !w[0];
  endtask : shift_word
  task automatic pulse_rst();
    o_loop_rst <= 1'h1;
    repeat (8) @(posedge i_clk);
    o_loop_rst <= 1'h0;
  endtask : pulse_rst
endmodule : csp_user_model

/* File: verification/tb_csp_loop_ctrl.sv */
// Self-checking bench of the loop control block
`timescale 1ns/1ps
module tb_csp_loop_ctrl;
  import csp_pkg::*;
  typedef struct packed {
    csp_cfg_t cfg; logic [1:0] src; logic fb_loop; logic [7:0] edges; logic lock;
  } csp_row_t;
  logic       i_clk = 1'h0;
  logic       i_sys_rst = 1'h1;
  csp_phase_t dyn_phase = '0;
  logic       ref_pin, ref_osc, ref_fab, fb_pin, sclk, sdat, lrst, clk_gbuf, clk_fab, lock;
  csp_cfg_t   active, pending;
  int         num_errors = 0;
  int         num_checks = 0;
  always #25 i_clk = !i_clk;
  csp_loop_ctrl dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ref_pin(ref_pin),
    .i_ref_osc(ref_osc), .i_ref_fabric(ref_fab), .i_fb_pin(fb_pin), .i_cfg_shift_clk(sclk),
    .i_cfg_shift_data(sdat), .i_loop_rst(lrst), .i_dyn_phase(dyn_phase),
    .o_synth_clk_gbuf(clk_gbuf), .o_synth_clk_fabric(clk_fab), .o_lock(lock),
    .o_active_cfg(active), .o_pending_cfg(pending));
  csp_user_model u_usr (.i_clk(i_clk), .i_synth_clk(clk_fab), .o_ref_pin(ref_pin),
    .o_ref_osc(ref_osc), .o_ref_fabric(ref_fab), .o_fb_pin(fb_pin), .o_shift_clk(sclk),
    .o_shift_data(sdat), .o_loop_rst(lrst));
  function automatic csp_cfg_t mk(input logic [6:0] fb, input logic [2:0] ex,
                                  input logic [1:0] rs, input logic fs);
    return '{fb, ex, rs, fs, 1'h0, '{1'h0, 8'h00}};
  endfunction : mk
  // Edge counts are over 64 reference periods; FF marks a row with no output check
  // The last row also carries a zero multiplier, which must be raised to one
  csp_row_t rows [6] = '{
    '{mk(7'h01, 3'h0, REF_SEL_PIN, FB_SEL_FABRIC), 2'h0, 1'h0, 8'h40, 1'h1},
    '{mk(7'h04, 3'h1, REF_SEL_OSC, FB_SEL_FABRIC), 2'h1, 1'h0, 8'h80, 1'h1},
    '{mk(7'h03, 3'h0, REF_SEL_FABRIC, FB_SEL_FABRIC), 2'h2, 1'h0, 8'hC0, 1'h1},
    '{mk(7'h08, 3'h7, REF_SEL_PIN, FB_SEL_FABRIC), 2'h0, 1'h0, 8'h08, 1'h1},
    '{mk(7'h02, 3'h0, REF_SEL_PIN, FB_SEL_PIN), 2'h0, 1'h1, 8'h80, 1'h1},
    '{mk(7'h00, 3'h0, REF_SEL_OSC, FB_SEL_FABRIC), 2'h0, 1'h0, 8'hFF, 1'h0}};
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_lock(input int lim, input logic must, output int n);
    n = 0;
    while (lock !== 1'h1 && n < lim) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (must && lock !== 1'h1) begin
      num_errors++;
      $display("ERROR t=%0t lock wait ran out got=%h exp=%h", $time, lock, 1'h1);
      give_verdict();
    end
  endtask : wait_lock
  task automatic count_edges(input int n, output int e);
    logic prev;
    e = 0;
    prev = clk_gbuf;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      if (clk_gbuf === 1'h1 && prev === 1'h0) e++;
      prev = clk_gbuf;
    end
  endtask : count_edges
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    csp_cfg_t c;
    int       n;
    int       e;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_clk);
    #1;
    check(active, CFG_RESET);
    check(pending, CFG_RESET);
    check(lock, 1'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      u_usr.ref_wire <= rows[i].src;
      u_usr.fb_loop <= rows[i].fb_loop;
      u_usr.shift_word(rows[i].cfg);
      u_usr.pulse_rst();
      c = rows[i].cfg;
      if (c.out_exp > OUT_EXP_MAX) c.out_exp = OUT_EXP_MAX;
      if (c.fb_div == 7'h00) c.fb_div = 7'h01;
      #1;
      check(pending, rows[i].cfg);
      check(active, c);
      wait_lock(1500, rows[i].lock, n);
      check(lock, rows[i].lock);
      if (rows[i].edges != 8'hFF) begin
        count_edges(2560, e);
        check(32'(e >= int'(rows[i].edges) - 1 && e <= int'(rows[i].edges) + 1), 32'h1);
      end
      $display("row %0d done", i);
    end
    c = mk(7'h01, 3'h0, REF_SEL_PIN, FB_SEL_FABRIC);
    c.ph_dynamic = 1'h1;
    u_usr.ref_wire <= 2'h0;
    u_usr.shift_word(c);
    u_usr.pulse_rst();
    wait_lock(1500, 1'h1, n);
    check(lock, 1'h1);
    @(posedge i_clk);
    dyn_phase <= '{dly: 1'h1, mag: 8'h05};
    repeat (8) @(posedge i_clk);
    #1;
    check(lock, 1'h0);
    wait_lock(1500, 1'h1, n);
    check(lock, 1'h1);
    check(32'(n >= SETTLE_CYC - 8), 32'h1);
    $display("dynamic phase test done");
    @(posedge i_clk);
    i_sys_rst <= 1'h1;
    @(posedge i_clk);
    #1;
    check(lock, 1'h0);
    check(active, CFG_RESET);
    check(pending, CFG_RESET);
    @(posedge i_clk);
    i_sys_rst <= 1'h0;
    wait_lock(1500, 1'h1, n);
    check(lock, 1'h1);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : tb_csp_loop_ctrl
